// ### dmd_pkg.sv
// Purpose: constants for the data-move instruction decoder
// Assumes: 16-bit instruction words, 8-bit data, 12-bit data addresses
// Notes: access bank split point and index threshold are plain defaults
package dmd_pkg;
   localparam logic [7:0] OPC_LOAD_LIT = 8'h0e;
   localparam logic [6:0] OPC_STORE_ACC = 7'h37;
   localparam int INSTR_W = 16;
   localparam int ADDR_W = 12;
   localparam logic [7:0] IDX_LIMIT = 8'h5f;
   localparam logic [7:0] ACC_SPLIT = 8'h60;
   localparam logic [3:0] SFR_BANK = 4'hf;
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [1:0] PH_DECODE = 2'h0;
   localparam logic [1:0] PH_WRITE = 2'h3;
   typedef enum logic [1:0] {
      DMD_Q1,
      DMD_Q2,
      DMD_Q3,
      DMD_Q4
   } dmd_phase_t;
endpackage

// ### dmd_decode.sv
// Purpose: decode and execute literal load and accumulator store
// Assumes: one instruction presented per four-phase cycle, taken at phase 1
// Notes: status flags are never touched by these two instructions

// Summary of operation
// - Upper byte 0000 1110 loads the low eight bits into the working register.
// - Upper seven bits 0110 111 store the working register to the 8-bit file address.
// - A store with bank-select bit zero and no indexed offset resolves its address in the access bank.
// - A store with bank-select bit one joins the bank select register and the address.
// - With extended set on and bank-select zero, addresses up to 5Fh become indexed offsets.
module dmd_decode (
   input wire logic clk,
   input wire logic rst,
   input wire logic instr_valid,
   input wire logic [15:0] instr_word,
   input wire logic [3:0] bank_select_register,
   input wire logic ext_set_enable,
   input wire logic [11:0] index_base,
   output logic [7:0] accumulator,
   output logic [1:0] phase,
   output logic busy,
   output logic file_we,
   output logic [11:0] file_addr,
   output logic [7:0] file_wdata,
   output logic status_we
);
   typedef struct packed {
      // sequencing
      dmd_pkg::dmd_phase_t ph;
      logic busy;
      logic is_load;
      logic is_store;

      // held word and its results
      logic [15:0] ir;
      logic [7:0] operand;
      logic [11:0] addr;
      logic [7:0] acc;

      // store port
      logic we;
      logic [11:0] wa;
      logic [7:0] wd;
      logic sw;
   } dmd_state_t;

   dmd_state_t s_q;
   dmd_state_t s_d;

   // phase of the current cycle
   logic in_q1;
   logic in_q4;

   // word offered at the pins
   logic take;
   logic [7:0] in_upper8;
   logic [6:0] in_upper7;
   logic hit_load;
   logic hit_store;

   // word held since the take
   logic a_bit;
   logic [7:0] f_field;
   logic [7:0] lit_field;
   logic f_le_limit;
   logic f_in_idx;
   logic f_low_access;
   logic use_bank;
   logic use_idx;
   logic use_low;

   // candidate store addresses
   logic [11:0] idx_addr;
   logic [11:0] acc_low_addr;
   logic [11:0] acc_high_addr;
   logic [11:0] bank_addr;
   logic [11:0] store_addr;

   // commit strobes of the last phase
   logic load_commit;
   logic store_commit;

   // phase decode
   assign in_q1 = (s_q.ph == dmd_pkg::DMD_Q1);
   assign in_q4 = (s_q.ph == dmd_pkg::DMD_Q4);

   assign take = in_q1 && instr_valid;
   assign in_upper8 = instr_word[15:8];
   assign in_upper7 = instr_word[15:9];
   assign hit_load = (in_upper8 == dmd_pkg::OPC_LOAD_LIT);
   assign hit_store = (in_upper7 == dmd_pkg::OPC_STORE_ACC);

   assign a_bit = s_q.ir[8];
   assign f_field = s_q.ir[7:0];
   assign lit_field = s_q.ir[7:0];

   assign f_le_limit = (f_field <= dmd_pkg::IDX_LIMIT);
   assign f_in_idx = ext_set_enable && f_le_limit;
   assign f_low_access = (f_field < dmd_pkg::ACC_SPLIT);

   // bank bit set wins, then indexed, then the access bank halves
   assign use_bank = a_bit;
   assign use_idx = !a_bit && f_in_idx;
   assign use_low = !a_bit && !f_in_idx && f_low_access;

   // the indexed sum wraps inside the 12-bit space
   assign idx_addr = index_base + {4'h0, f_field};
   assign acc_low_addr = {4'h0, f_field};
   assign acc_high_addr = {dmd_pkg::SFR_BANK, f_field};
   assign bank_addr = {bank_select_register, f_field};

   // later tests override earlier ones, highest priority last
   always_comb begin
      store_addr = acc_high_addr;
      if (use_low) begin
         store_addr = acc_low_addr;
      end
      if (use_idx) begin
         store_addr = idx_addr;
      end
      if (use_bank) begin
         store_addr = bank_addr;
      end
   end

   // commit only in the write phase
   assign load_commit = in_q4 && s_q.is_load;
   assign store_commit = in_q4 && s_q.is_store;

   // next state of every register
   always_comb begin
      s_d = s_q;
      s_d.we = 1'b0;
      s_d.sw = 1'b0;

      case (s_q.ph)
         // decode and take
         dmd_pkg::DMD_Q1: begin
            if (take) begin
               s_d.busy = 1'b1;
               s_d.ir = instr_word;
               s_d.is_load = hit_load;
               s_d.is_store = hit_store;
               s_d.ph = dmd_pkg::DMD_Q2;
            end else begin
               s_d.busy = 1'b0;
               s_d.is_load = 1'b0;
               s_d.is_store = 1'b0;
            end
         end

         // read operand and form address
         dmd_pkg::DMD_Q2: begin
            s_d.operand = lit_field;
            s_d.addr = store_addr;
            s_d.ph = dmd_pkg::DMD_Q3;
         end

         // latch store port
         dmd_pkg::DMD_Q3: begin
            s_d.wd = s_q.acc;
            s_d.wa = s_q.addr;
            s_d.ph = dmd_pkg::DMD_Q4;
         end

         // write destination
         dmd_pkg::DMD_Q4: begin
            if (load_commit) begin
               s_d.acc = s_q.operand;
            end
            if (store_commit) begin
               s_d.we = 1'b1;
            end

            s_d.busy = 1'b0;
            s_d.is_load = 1'b0;
            s_d.is_store = 1'b0;
            s_d.ph = dmd_pkg::DMD_Q1;
         end

         default: begin
            s_d.ph = dmd_pkg::DMD_Q1;
         end
      endcase
   end

   // synchronous reset to the idle phase
   always_ff @(posedge clk) begin
      if (rst) begin
         s_q.ph <= dmd_pkg::DMD_Q1;
         s_q.busy <= 1'b0;
         s_q.is_load <= 1'b0;
         s_q.is_store <= 1'b0;

         s_q.ir <= 16'h0000;
         s_q.operand <= 8'h00;
         s_q.addr <= 12'h000;
         s_q.acc <= dmd_pkg::ACC_RESET;

         s_q.we <= 1'b0;
         s_q.wa <= 12'h000;
         s_q.wd <= 8'h00;
         s_q.sw <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   // core outputs straight from the register
   assign accumulator = s_q.acc;
   assign phase = s_q.ph;
   assign busy = s_q.busy;

   // store port outputs straight from the register
   assign file_we = s_q.we;
   assign file_addr = s_q.wa;
   assign file_wdata = s_q.wd;
   assign status_we = s_q.sw;
endmodule

// ### dmd_decode_checker.sv
// Purpose: port checks for dmd_decode
// Assumes: take at phase 0, results seen four edges later
// Notes: bind follows the module
module dmd_decode_checker (input wire logic clk, rst, instr_valid, ext_set_enable, file_we,
   status_we, busy, input wire logic [15:0] instr_word,
   input wire logic [3:0] bank_select_register,
   input wire logic [11:0] index_base, file_addr, input wire logic [7:0] accumulator, file_wdata,
   input wire logic [1:0] phase);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire [7:0] f = instr_word[7:0];
   wire tk = instr_valid && phase == 2'h0;
   wire st = tk && instr_word[15:9] == dmd_pkg::OPC_STORE_ACC;
   wire ix = st && !instr_word[8] && ext_set_enable && f <= dmd_pkg::IDX_LIMIT;
   load_value_a: assert property (tk && instr_word[15:8] == dmd_pkg::OPC_LOAD_LIT |->
      ##4 accumulator == $past(f, 4)) else $error("load value");
   store_data_a: assert property (st |-> ##4 file_we &&
      file_wdata == $past(accumulator, 4)) else $error("store data");
   access_bank_a: assert property (st && !instr_word[8] && !ix |-> ##4
      file_addr == {($past(f, 4) < dmd_pkg::ACC_SPLIT) ? 4'h0 : dmd_pkg::SFR_BANK, $past(f, 4)})
      else $error("access bank");
   bank_sel_a: assert property (st && instr_word[8] |-> ##4
      file_addr == {$past(bank_select_register, 4), $past(f, 4)}) else $error("bank select");
   indexed_a: assert property (ix |-> ##4
      file_addr == $past(index_base, 4) + 12'($past(f, 4))) else $error("indexed");
   phase_seq_a: assert property (tk |=> phase == 2'h1 && !status_we ##1 phase == 2'h2
      ##1 phase == 2'h3 ##1 phase == 2'h0) else $error("phase order");
   load_c: cover property (tk && instr_word[15:8] == dmd_pkg::OPC_LOAD_LIT);
   index_c: cover property (ix);
   bank_c: cover property (st && instr_word[8]);
   access_c: cover property (st && !instr_word[8] && !ix);
   busy_flag_a: assert property (tk |=> busy [*3] ##1 !busy)
      else $error("busy span");
   no_write_a: assert property (tk && !st |-> ##4 !file_we)
      else $error("stray write");
endmodule
bind dmd_decode dmd_decode_checker u_dmd_decode_checker (.*);

// ### tb_data_move_instr_decode.sv
// Purpose: bench for dmd_decode
// Assumes: 50 ns clock, inputs 5 ns after the edge
// Notes: store cases of t_move in one table, plus one bank-select store in t_load
module tb_data_move_instr_decode;
   timeunit 1ns / 1ns;
   logic clk = 1'b0, rst = 1'b1, instr_valid = 1'b0, ext_set_enable = 1'b0, file_we, status_we;
   logic [15:0] instr_word = 16'h0000;
   logic [3:0] bank_select_register = 4'h0;
   logic [11:0] index_base = 12'h100, file_addr;
   logic [7:0] accumulator, file_wdata;
   logic [1:0] phase;
   logic busy;
   int bad_count = 0, tests_run = 0;
   always #25 clk = ~clk;
   dmd_decode u_dmd_decode (.clk, .rst, .instr_valid, .instr_word, .bank_select_register,
      .ext_set_enable, .index_base, .accumulator, .phase, .busy, .file_we, .file_addr,
      .file_wdata, .status_we);
   task automatic chk(logic [11:0] got, logic [11:0] exp);
      tests_run++;
      bad_count += int'(got !== exp);
      if (got !== exp) $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
   endtask
   task automatic run(logic [15:0] w);
      {instr_valid, instr_word} = {1'b1, w};
      @(posedge clk);
      #5 instr_valid = 1'b0;
      chk({9'h0, busy, phase}, 12'h005);
      repeat (3) @(posedge clk);
      #5;
      chk({9'h0, busy, phase}, 12'h000);
   endtask
   task automatic t_move;
      logic [31:0] t [7] = '{32'h0319c39c, 32'h0a100a00, 32'h0305f05f, 32'h03060f60,
         32'h1305f15f, 32'h13060f60, 32'h13110310};
      run(16'h0eff);
      chk({4'h0, accumulator}, 12'h0ff);
      foreach (t[i]) begin
         {ext_set_enable, bank_select_register} = t[i][28:24];
         run({7'h37, t[i][20:12]});
         chk(file_addr, t[i][11:0]);
         chk({2'h0, status_we, file_we, file_wdata}, 12'h1ff);
      end
      $display("move test done");
   endtask
   task automatic t_load;
      run(16'h0e5a);
      chk({4'h0, accumulator}, 12'h05a);
      bank_select_register = 4'h2;
      run(16'h6f20);
      chk(file_addr, 12'h220);
      chk({3'h0, file_we, file_wdata}, 12'h15a);
      run(16'hffff);
      chk({3'h0, file_we, accumulator}, 12'h05a);
      $display("load test done");
   endtask
   task automatic t_reset_mid;
      {instr_valid, instr_word} = {1'b1, 16'h0e77};
      @(posedge clk);
      #5 instr_valid = 1'b0;
      rst = 1'b1;
      @(posedge clk);
      #5 chk({2'h0, busy, phase, accumulator}, 12'h000);
      chk({11'h0, file_we}, 12'h000);
      @(posedge clk);
      #5 rst = 1'b0;
      run(16'h0e44);
      chk({4'h0, accumulator}, 12'h044);
      $display("reset test done");
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clk);
      #5 rst = 1'b0;
      t_move();
      t_load();
      t_reset_mid();
      give_verdict();
   end
endmodule
